// file: design/cdu_pkg.sv
// cdu_pkg: constants, register map and bus carriers of the periodic interrupt block
package cdu_pkg;
  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int CLK_HZ = 125_000_000;
  localparam int BASE_HZ = 4096;
  localparam int BASE_DIV = CLK_HZ / BASE_HZ;
  localparam int CD_RTN_FAST_NS = 122_000;
  localparam int CD_RTN_SLOW_NS = 7_813_000;
  localparam int UPD_RTN_SEC_NS = 500_000_000;
  localparam int UPD_RTN_MIN_NS = 15_600_000;
  localparam logic [31:0] CD_RTN_FAST_CYC = 32'(CD_RTN_FAST_NS / CLK_PERIOD_NS);
  localparam logic [31:0] CD_RTN_SLOW_CYC = 32'(CD_RTN_SLOW_NS / CLK_PERIOD_NS);
  localparam logic [31:0] UPD_RTN_SEC_CYC = 32'(UPD_RTN_SEC_NS / CLK_PERIOD_NS);
  localparam logic [31:0] UPD_RTN_MIN_CYC = 32'(UPD_RTN_MIN_NS / CLK_PERIOD_NS);
  // ==========================================================================
  // timebase and countdown
  localparam logic [5:0] SUB64_LAST = 6'h3F;
  localparam logic [11:0] PRESC_LAST = 12'hFFF;
  localparam logic [11:0] PRESC_ONE = 12'h001;
  localparam logic [5:0] SEC_LAST = 6'h3B;
  localparam logic [5:0] SEC_ONE = 6'h01;
  localparam logic [11:0] CNT_ONE = 12'h001;
  typedef enum logic [1:0] {
    SRC_4096 = 2'b00,
    SRC_64 = 2'b01,
    SRC_1HZ = 2'b10,
    SRC_MIN = 2'b11
  } cdu_src_e;
  // ==========================================================================
  // register map, byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_IRQEN = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_TVAL0 = 8'h0C;
  localparam logic [7:0] ADDR_TVAL1 = 8'h10;
  localparam logic [7:0] ADDR_SECONDS = 8'h14;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_SRC = 1;
  localparam int CTRL_UPDATE_PERIOD_SELECT = 3;
  localparam int CTRL_HALT = 4;
  localparam int CTRL_EVENT_SYNC_ENABLE = 5;
  localparam int BIT_CD = 0;
  localparam int BIT_UPD = 1;
  localparam int BIT_ALM = 2;
  localparam int ST_PIN = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================================
  // AXI4-Lite carriers
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } cdu_axi_req_s;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cdu_axi_rsp_s;
endpackage : cdu_pkg

// file: design/cdu_tick_div.sv
// cdu_tick_div: clock divider giving a one-cycle enable pulse every Div cycles
`timescale 1ns/1ns
module cdu_tick_div #(
  parameter int Div = 4
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic en,
  input wire logic clr,
  output logic tick
);
  localparam int W = (Div > 1) ? $clog2(Div) : 1;
  localparam logic [W-1:0] LAST = W'(Div - 1);
  logic [W-1:0] cnt_reg, cnt_next;
  logic tick_reg, tick_next;
  always_comb begin
    cnt_next = cnt_reg;
    tick_next = 1'b0;
    if (clr) begin
      cnt_next = '0;
    end else if (en) begin
      tick_next = (cnt_reg == LAST);
      cnt_next = (cnt_reg == LAST) ? '0 : cnt_reg + 1'b1;
    end
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end
  assign tick = tick_reg;
endmodule : cdu_tick_div

// file: design/cdu_pulse_timer.sv
// cdu_pulse_timer: retriggerable auto-return timer, active for lenCycles after start
`timescale 1ns/1ns
module cdu_pulse_timer (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic start,
  input wire logic cancel,
  input wire logic [31:0] lenCycles,
  output logic active
);
  logic [31:0] left_reg, left_next;
  // start beats cancel so a fresh event is never lost
  always_comb begin
    left_next = left_reg;
    if (start) begin
      left_next = lenCycles;
    end else if (cancel) begin
      left_next = '0;
    end else if (left_reg != '0) begin
      left_next = left_reg - 32'h1;
    end
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      left_reg <= '0;
    end else begin
      left_reg <= left_next;
    end
  end
  assign active = (left_reg != '0);
endmodule : cdu_pulse_timer

// file: design/cdu_irq_top.sv
// cdu_irq_top: countdown, periodic update and alarm interrupt logic with AXI4-Lite registers
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
module cdu_irq_top
  import cdu_pkg::*;
#(
  parameter int BaseDiv = BASE_DIV,
  parameter logic [31:0] CdRtnFast = CD_RTN_FAST_CYC,
  parameter logic [31:0] CdRtnSlow = CD_RTN_SLOW_CYC,
  parameter logic [31:0] UpdRtnSec = UPD_RTN_SEC_CYC,
  parameter logic [31:0] UpdRtnMin = UPD_RTN_MIN_CYC
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire cdu_axi_req_s axiReq,
  output cdu_axi_rsp_s axiRsp,
  input wire logic alarmEvent,
  input wire logic eventInput,
  input wire logic intPinIn,
  output logic intPinOut,
  output logic intPinOe,
  output logic updatePulseInternal,
  output logic alarmSignalInternal
);
  // ==========================================================================
  // bus slave state
  logic awHeld_reg, awHeld_next;
  logic [7:0] awAddr_reg, awAddr_next;
  logic wHeld_reg, wHeld_next;
  logic [31:0] wData_reg, wData_next;
  logic wStrb0_reg, wStrb0_next;
  logic bValid_reg, bValid_next;
  logic [1:0] bResp_reg, bResp_next;
  logic rValid_reg, rValid_next;
  logic [31:0] rData_reg, rData_next;
  logic [1:0] rResp_reg, rResp_next;
  logic wrFire, arFire, awMapped, arMapped;
  logic wrCtrl, wrIrqen, wrStat, wrTv0, wrTv1, wrSec;
  // ==========================================================================
  // block state
  logic run_reg, run_next;
  logic [1:0] src_reg, src_next;
  logic update_period_select_reg, update_period_select_next;
  logic halt_reg, halt_next;
  logic event_sync_enable_reg, event_sync_enable_next;
  logic cdIrqEn_reg, cdIrqEn_next;
  logic updIrqEn_reg, updIrqEn_next;
  logic almIrqEn_reg, almIrqEn_next;
  logic [11:0] preset_reg, preset_next;
  logic [11:0] count_reg, count_next;
  logic firstTick_reg, firstTick_next;
  logic cdFlag_reg, cdFlag_next;
  logic updFlag_reg, updFlag_next;
  logic almFlag_reg, almFlag_next;
  logic [11:0] presc_reg, presc_next;
  logic [5:0] sec_reg, sec_next;
  logic evPrev_reg, evPrev_next;
  logic intOe_reg, intOe_next;
  logic updInt_reg, updInt_next;
  logic almInt_reg, almInt_next;
  logic baseTick, tick64, tick1, tickMin, srcTick, syncClr;
  logic runStart, cdEvent, updEvt, updEvtEn;
  logic cdPulse, updPulse, cdLow, updLow, almLow;
  logic [31:0] cdLen, updLen;
  // ==========================================================================
  // AXI4-Lite slave
  assign wrFire = awHeld_reg && wHeld_reg && !bValid_reg;
  assign arFire = axiReq.arvalid && !rValid_reg;
  assign awMapped = (awAddr_reg == ADDR_CTRL) || (awAddr_reg == ADDR_IRQEN) ||
                    (awAddr_reg == ADDR_STATUS) || (awAddr_reg == ADDR_TVAL0) ||
                    (awAddr_reg == ADDR_TVAL1) || (awAddr_reg == ADDR_SECONDS);
  assign arMapped = (axiReq.araddr == ADDR_CTRL) || (axiReq.araddr == ADDR_IRQEN) ||
                    (axiReq.araddr == ADDR_STATUS) || (axiReq.araddr == ADDR_TVAL0) ||
                    (axiReq.araddr == ADDR_TVAL1) || (axiReq.araddr == ADDR_SECONDS);
  // all fields live in byte lane 0, so lane 0 strobe gates every write
  assign wrCtrl = wrFire && wStrb0_reg && (awAddr_reg == ADDR_CTRL);
  assign wrIrqen = wrFire && wStrb0_reg && (awAddr_reg == ADDR_IRQEN);
  assign wrStat = wrFire && wStrb0_reg && (awAddr_reg == ADDR_STATUS);
  assign wrTv0 = wrFire && wStrb0_reg && (awAddr_reg == ADDR_TVAL0);
  assign wrTv1 = wrFire && wStrb0_reg && (awAddr_reg == ADDR_TVAL1);
  assign wrSec = wrFire && wStrb0_reg && (awAddr_reg == ADDR_SECONDS);

  always_comb begin
    awHeld_next = awHeld_reg;
    awAddr_next = awAddr_reg;
    wHeld_next = wHeld_reg;
    wData_next = wData_reg;
    wStrb0_next = wStrb0_reg;
    bValid_next = bValid_reg;
    bResp_next = bResp_reg;
    if (axiReq.awvalid && !awHeld_reg) begin
      awHeld_next = 1'b1;
      awAddr_next = axiReq.awaddr;
    end
    if (axiReq.wvalid && !wHeld_reg) begin
      wHeld_next = 1'b1;
      wData_next = axiReq.wdata;
      wStrb0_next = axiReq.wstrb[0];
    end
    if (bValid_reg && axiReq.bready) begin
      bValid_next = 1'b0;
    end
    if (wrFire) begin
      awHeld_next = 1'b0;
      wHeld_next = 1'b0;
      bValid_next = 1'b1;
      bResp_next = awMapped ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_comb begin
    rValid_next = rValid_reg;
    rData_next = rData_reg;
    rResp_next = rResp_reg;
    if (rValid_reg && axiReq.rready) begin
      rValid_next = 1'b0;
    end
    if (arFire) begin
      rValid_next = 1'b1;
      rResp_next = arMapped ? RESP_OKAY : RESP_SLVERR;
      rData_next = '0;
      unique case (axiReq.araddr)
        ADDR_CTRL: begin
          rData_next[CTRL_RUN] = run_reg;
          rData_next[CTRL_SRC +: 2] = src_reg;
          rData_next[CTRL_UPDATE_PERIOD_SELECT] = update_period_select_reg;
          rData_next[CTRL_HALT] = halt_reg;
          rData_next[CTRL_EVENT_SYNC_ENABLE] = event_sync_enable_reg;
        end
        ADDR_IRQEN: begin
          rData_next[BIT_CD] = cdIrqEn_reg;
          rData_next[BIT_UPD] = updIrqEn_reg;
          rData_next[BIT_ALM] = almIrqEn_reg;
        end
        ADDR_STATUS: begin
          rData_next[BIT_CD] = cdFlag_reg;
          rData_next[BIT_UPD] = updFlag_reg;
          rData_next[BIT_ALM] = almFlag_reg;
          rData_next[ST_PIN] = intPinIn;
        end
        ADDR_TVAL0: rData_next[7:0] = preset_reg[7:0];
        ADDR_TVAL1: rData_next[3:0] = preset_reg[11:8];
        ADDR_SECONDS: rData_next[5:0] = sec_reg;
        default: rData_next = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      awHeld_reg <= 1'b0;
      awAddr_reg <= '0;
      wHeld_reg <= 1'b0;
      wData_reg <= '0;
      wStrb0_reg <= 1'b0;
      bValid_reg <= 1'b0;
      bResp_reg <= RESP_OKAY;
      rValid_reg <= 1'b0;
      rData_reg <= '0;
      rResp_reg <= RESP_OKAY;
    end else begin
      awHeld_reg <= awHeld_next;
      awAddr_reg <= awAddr_next;
      wHeld_reg <= wHeld_next;
      wData_reg <= wData_next;
      wStrb0_reg <= wStrb0_next;
      bValid_reg <= bValid_next;
      bResp_reg <= bResp_next;
      rValid_reg <= rValid_next;
      rData_reg <= rData_next;
      rResp_reg <= rResp_next;
    end
  end

  always_comb begin
    axiRsp = '0;
    axiRsp.awready = !awHeld_reg;
    axiRsp.wready = !wHeld_reg;
    axiRsp.bvalid = bValid_reg;
    axiRsp.bresp = bResp_reg;
    axiRsp.arready = !rValid_reg;
    axiRsp.rvalid = rValid_reg;
    axiRsp.rdata = rData_reg;
    axiRsp.rresp = rResp_reg;
  end
  // ==========================================================================
  // timebase: 4096 Hz base, 64 Hz, seconds, minutes
  // restarting the divider and prescaler stretches or cuts the running period
  assign syncClr = wrSec || (event_sync_enable_reg && eventInput && !evPrev_reg);
  cdu_tick_div #(
    .Div(BaseDiv)
  ) baseDiv (
    .ref_clk(ref_clk),
    .reset(reset),
    .en(!halt_reg),
    .clr(syncClr),
    .tick(baseTick)
  );
  assign tick64 = baseTick && (presc_reg[5:0] == SUB64_LAST);
  assign tick1 = baseTick && (presc_reg == PRESC_LAST);
  assign tickMin = tick1 && (sec_reg == SEC_LAST);

  always_comb begin
    presc_next = presc_reg;
    sec_next = sec_reg;
    evPrev_next = eventInput;
    if (syncClr) begin
      presc_next = '0;
    end else if (baseTick) begin
      presc_next = presc_reg + PRESC_ONE;
    end
    if (wrSec) begin
      sec_next = (wData_reg[5:0] > SEC_LAST) ? '0 : wData_reg[5:0];
    end else if (tick1) begin
      sec_next = (sec_reg == SEC_LAST) ? '0 : sec_reg + SEC_ONE;
    end
  end
  // ==========================================================================
  // control registers and countdown
  always_comb begin
    unique case (cdu_src_e'(src_reg))
      SRC_4096: srcTick = baseTick;
      SRC_64: srcTick = tick64;
      SRC_1HZ: srcTick = tick1;
      SRC_MIN: srcTick = tickMin;
    endcase
  end
  // start is not aligned to the source tick; swallowing the first tick keeps the first period within n..n+1 ticks
  assign runStart = wrCtrl && wData_reg[CTRL_RUN] && !run_reg;
  assign cdEvent = run_reg && srcTick && !firstTick_reg && (count_reg == CNT_ONE);

  always_comb begin
    run_next = run_reg;
    src_next = src_reg;
    update_period_select_next = update_period_select_reg;
    halt_next = halt_reg;
    event_sync_enable_next = event_sync_enable_reg;
    cdIrqEn_next = cdIrqEn_reg;
    updIrqEn_next = updIrqEn_reg;
    almIrqEn_next = almIrqEn_reg;
    preset_next = preset_reg;
    count_next = count_reg;
    firstTick_next = firstTick_reg;
    if (wrCtrl) begin
      run_next = wData_reg[CTRL_RUN];
      src_next = wData_reg[CTRL_SRC +: 2];
      update_period_select_next = wData_reg[CTRL_UPDATE_PERIOD_SELECT];
      halt_next = wData_reg[CTRL_HALT];
      event_sync_enable_next = wData_reg[CTRL_EVENT_SYNC_ENABLE];
    end
    if (wrIrqen) begin
      cdIrqEn_next = wData_reg[BIT_CD];
      updIrqEn_next = wData_reg[BIT_UPD];
      almIrqEn_next = wData_reg[BIT_ALM];
    end
    if (wrTv0) begin
      preset_next[7:0] = wData_reg[7:0];
    end
    if (wrTv1) begin
      preset_next[11:8] = wData_reg[3:0];
    end
    if (runStart) begin
      count_next = preset_reg;
      firstTick_next = 1'b1;
    end else if (run_reg && srcTick && firstTick_reg) begin
      firstTick_next = 1'b0;
    end else if (cdEvent) begin
      count_next = preset_reg;
    end else if (run_reg && srcTick && (count_reg != '0)) begin
      count_next = count_reg - CNT_ONE;
    end
  end
  // ==========================================================================
  // flags, auto-return timers and interrupt pin
  assign updEvt = update_period_select_reg ? tickMin : tick1;
  assign updEvtEn = updEvt && updIrqEn_reg;
  assign cdLen = (cdu_src_e'(src_reg) == SRC_4096) ? CdRtnFast : CdRtnSlow;
  assign updLen = update_period_select_reg ? UpdRtnMin : UpdRtnSec;

  cdu_pulse_timer cdTimer (
    .ref_clk(ref_clk),
    .reset(reset),
    .start(cdEvent && cdIrqEn_reg),
    .cancel(!cdFlag_reg || !cdIrqEn_reg),
    .lenCycles(cdLen),
    .active(cdPulse)
  );
  cdu_pulse_timer updTimer (
    .ref_clk(ref_clk),
    .reset(reset),
    .start(updEvtEn),
    .cancel(!updFlag_reg || !updIrqEn_reg),
    .lenCycles(updLen),
    .active(updPulse)
  );
  assign cdLow = cdPulse && cdFlag_reg && cdIrqEn_reg;
  assign updLow = updPulse && updFlag_reg && updIrqEn_reg;
  assign almLow = almFlag_reg && almIrqEn_reg;

  // a status write of 0 clears a flag; an event in the same cycle wins
  always_comb begin
    cdFlag_next = cdEvent || (cdFlag_reg && !(wrStat && !wData_reg[BIT_CD]));
    updFlag_next = updEvtEn || (updFlag_reg && !(wrStat && !wData_reg[BIT_UPD]));
    almFlag_next = alarmEvent || (almFlag_reg && !(wrStat && !wData_reg[BIT_ALM]));
    intOe_next = cdLow || updLow || almLow;
    updInt_next = updEvtEn;
    almInt_next = almLow;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      run_reg <= 1'b0;
      src_reg <= SRC_4096;
      update_period_select_reg <= 1'b0;
      halt_reg <= 1'b0;
      event_sync_enable_reg <= 1'b0;
      cdIrqEn_reg <= 1'b0;
      updIrqEn_reg <= 1'b0;
      almIrqEn_reg <= 1'b0;
      preset_reg <= '0;
      count_reg <= '0;
      firstTick_reg <= 1'b0;
      cdFlag_reg <= 1'b0;
      updFlag_reg <= 1'b0;
      almFlag_reg <= 1'b0;
      presc_reg <= '0;
      sec_reg <= '0;
      evPrev_reg <= 1'b0;
      intOe_reg <= 1'b0;
      updInt_reg <= 1'b0;
      almInt_reg <= 1'b0;
    end else begin
      run_reg <= run_next;
      src_reg <= src_next;
      update_period_select_reg <= update_period_select_next;
      halt_reg <= halt_next;
      event_sync_enable_reg <= event_sync_enable_next;
      cdIrqEn_reg <= cdIrqEn_next;
      updIrqEn_reg <= updIrqEn_next;
      almIrqEn_reg <= almIrqEn_next;
      preset_reg <= preset_next;
      count_reg <= count_next;
      firstTick_reg <= firstTick_next;
      cdFlag_reg <= cdFlag_next;
      updFlag_reg <= updFlag_next;
      almFlag_reg <= almFlag_next;
      presc_reg <= presc_next;
      sec_reg <= sec_next;
      evPrev_reg <= evPrev_next;
      intOe_reg <= intOe_next;
      updInt_reg <= updInt_next;
      almInt_reg <= almInt_next;
    end
  end
  // open drain: only ever pulls low
  assign intPinOut = 1'b0;
  assign intPinOe = intOe_reg;
  assign updatePulseInternal = updInt_reg;
  assign alarmSignalInternal = almInt_reg;
  // ==========================================================================
  // assertions
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  chk_cd_flag_set: assert property (cdEvent |=> cdFlag_reg)
    else $error("countdown flag not set after completion");
  chk_cd_flag_hold: assert property (
    cdFlag_reg && !(wrStat && !wData_reg[BIT_CD]) |=> cdFlag_reg)
    else $error("countdown flag dropped without host clear");
  chk_cd_pin_pulse: assert property (
    cdEvent && cdIrqEn_reg && !wrIrqen |=> cdPulse ##1 intPinOe)
    else $error("countdown completion did not pull pin low");
  chk_tv_read_preset: assert property (
    arFire && axiReq.araddr == ADDR_TVAL0 |=> rData_reg[7:0] == $past(preset_reg[7:0]))
    else $error("timer value read did not return preset");
  chk_upd_no_flag: assert property (
    updEvt && !updIrqEn_reg && !updFlag_reg && !wrStat |=> !updFlag_reg)
    else $error("update flag set while update irq disabled");
  chk_upd_cancel: assert property (
    !updFlag_reg && !cdLow && !almLow |=> !intPinOe)
    else $error("pin low for update after flag cleared");
  chk_halt_no_upd: assert property (halt_reg && !wrCtrl |=> !updEvt)
    else $error("update event while clock halted");
  chk_cd_reload: assert property (cdEvent && !runStart |=> count_reg == $past(preset_reg))
    else $error("countdown did not reload preset");
  chk_run_start: assert property (runStart |=> count_reg == $past(preset_reg) && run_reg)
    else $error("countdown did not start from preset");
  chk_zero_no_event: assert property (count_reg == '0 |-> !cdEvent)
    else $error("countdown event from zero count");
  chk_alarm_pin: assert property (almFlag_reg && almIrqEn_reg |=> intPinOe && alarmSignalInternal)
    else $error("alarm flag with enable did not pull pin low");
endmodule : cdu_irq_top

// file: test/cdu_int_wire.sv
// cdu_int_wire: pulled-up shared interrupt wire as the host sees it
`timescale 1ns/1ns
module cdu_int_wire (
  input wire logic intPinOe,
  input wire logic intPinOut,
  output logic intPinIn
);
  // open drain: only a low is driven, the pull-up gives the high
  assign intPinIn = intPinOe ? intPinOut : 1'b1;
endmodule : cdu_int_wire

// file: test/countdown_and_update_interrupts_tb_top.sv
// countdown_and_update_interrupts_tb_top: self-checking bench of the interrupt block
`timescale 1ns/1ns
module countdown_and_update_interrupts_tb_top;
  import cdu_pkg::*;
  // ==========================================================================
  // signals and design
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  cdu_axi_req_s req = '0;
  cdu_axi_rsp_s rsp;
  logic alarmEvent = 1'b0;
  logic eventInput = 1'b0;
  logic intPinIn, intPinOut, intPinOe, updatePulseInternal, alarmSignalInternal;
  logic [33:0] expQ[$];
  logic [7:0] rnd = 8'h40;
  logic [11:0] preset;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  int updSeen = 0;
  int cnt, lo, n;
  always #4 ref_clk = ~ref_clk;
  // short auto-return and divider counts keep the run brief
  cdu_irq_top #(.BaseDiv(4), .CdRtnFast(32'h5), .CdRtnSlow(32'h9), .UpdRtnSec(32'hD), .UpdRtnMin(32'h7)) dut_u (
    .ref_clk(ref_clk), .reset(reset), .axiReq(req), .axiRsp(rsp), .alarmEvent(alarmEvent),
    .eventInput(eventInput), .intPinIn(intPinIn), .intPinOut(intPinOut), .intPinOe(intPinOe),
    .updatePulseInternal(updatePulseInternal), .alarmSignalInternal(alarmSignalInternal));
  cdu_int_wire wire_u (.intPinOe(intPinOe), .intPinOut(intPinOut), .intPinIn(intPinIn));
  // ==========================================================================
  // helpers
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  function automatic logic [33:0] ok(input logic [31:0] d);
    return {RESP_OKAY, d};
  endfunction : ok
  task automatic test_done();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  task automatic cmpRead(input logic [33:0] got, input logic [33:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t read got %h exp %h", $time, got, exp);
    end
  endtask : cmpRead
  task automatic cmpVal(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask : cmpVal
  // ==========================================================================
  // bus master; sampling on the falling edge sees what the next rising edge takes
  task automatic axWrite(input logic [7:0] a, input logic [31:0] d);
    logic aDone, wDone, ta, tw;
    aDone = 1'b0;
    wDone = 1'b0;
    @(posedge ref_clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    while (!(aDone && wDone)) begin
      @(negedge ref_clk);
      ta = !aDone && rsp.awready === 1'b1;
      tw = !wDone && rsp.wready === 1'b1;
      @(posedge ref_clk);
      if (ta) req.awvalid <= 1'b0;
      if (tw) req.wvalid <= 1'b0;
      aDone = aDone | ta;
      wDone = wDone | tw;
    end
    while (rsp.bvalid !== 1'b1) @(negedge ref_clk);
    @(posedge ref_clk);
    req.bready <= 1'b0;
  endtask : axWrite
  task automatic axRead(input logic [7:0] a, input logic [33:0] exp);
    @(posedge ref_clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    expQ.push_back(exp);
    do @(negedge ref_clk); while (rsp.arready !== 1'b1);
    @(posedge ref_clk);
    req.arvalid <= 1'b0;
    do @(negedge ref_clk); while (rsp.rvalid !== 1'b1);
    @(posedge ref_clk);
    req.rready <= 1'b0;
  endtask : axRead
  task automatic waitOe(input logic lvl, output int k);
    k = 0;
    do begin
      @(negedge ref_clk);
      k++;
    end while (intPinOe !== lvl);
  endtask : waitOe
  // ==========================================================================
  // watchers
  always @(negedge ref_clk) begin
    if (rsp.rvalid === 1'b1 && req.rready === 1'b1) begin
      cmpRead({rsp.rresp, rsp.rdata}, expQ.pop_front());
    end
    if (updatePulseInternal === 1'b1) updSeen++;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 100000) begin
      n_mismatch++;
      test_done();
    end
  end
  // ==========================================================================
  // scenarios
  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    axRead(ADDR_STATUS, ok(32'h8));
    axRead(8'h18, {RESP_SLVERR, 32'h0});
    rnd = lfsr(rnd);
    preset[7:0] = rnd;
    rnd = lfsr(rnd);
    preset[11:8] = rnd[3:0];
    eventInput <= rnd[0];
    axWrite(ADDR_TVAL0, {24'h0, preset[7:0]});
    axWrite(ADDR_TVAL1, {28'h0, preset[11:8]});
    axRead(ADDR_TVAL0, ok({24'h0, preset[7:0]}));
    axRead(ADDR_TVAL1, ok({28'h0, preset[11:8]}));
    axWrite(ADDR_TVAL0, 32'h3);
    axWrite(ADDR_TVAL1, 32'h0);
    axWrite(ADDR_IRQEN, 32'h1);
    for (int k = 0; k < 2; k++) begin
      axWrite(ADDR_CTRL, {29'h0, k[1:0], 1'b1});
      eventInput <= ~eventInput;
      waitOe(1'b1, cnt);
      waitOe(1'b0, cnt);
      waitOe(1'b1, cnt);
      waitOe(1'b0, cnt);
      cmpVal(32'(cnt), (k != 0) ? 32'h9 : 32'h5, "cd pulse");
      waitOe(1'b1, lo);
      cmpVal(32'(cnt + lo), (k != 0) ? 32'h300 : 32'hC, "cd period");
    end
    axRead(ADDR_TVAL0, ok(32'h3));
    axWrite(ADDR_IRQEN, 32'h0);
    axWrite(ADDR_STATUS, 32'h0);
    repeat (800) @(posedge ref_clk);
    axWrite(ADDR_CTRL, 32'h0);
    repeat (50) @(posedge ref_clk);
    axRead(ADDR_STATUS, ok(32'h9));
    axWrite(ADDR_STATUS, 32'h0);
    axRead(ADDR_STATUS, ok(32'h8));
    axWrite(ADDR_TVAL0, 32'h0);
    axWrite(ADDR_CTRL, 32'h1);
    axWrite(ADDR_SECONDS, 32'h0);
    n = updSeen;
    repeat (17000) @(posedge ref_clk);
    axRead(ADDR_STATUS, ok(32'h8));
    axWrite(ADDR_CTRL, 32'h10);
    axWrite(ADDR_IRQEN, 32'h2);
    repeat (17000) @(posedge ref_clk);
    cmpVal(32'(updSeen), 32'(n), "update count");
    axWrite(ADDR_CTRL, 32'h20);
    axWrite(ADDR_SECONDS, 32'h0);
    // the late synced edge, not the seconds write, must set the delay
    eventInput <= 1'b0;
    repeat (100) @(posedge ref_clk);
    eventInput <= 1'b1;
    waitOe(1'b1, cnt);
    cmpVal({31'h0, cnt inside {[16370:16390]}}, 32'h1, "update delay");
    waitOe(1'b0, cnt);
    cmpVal(32'(cnt), 32'hD, "sec pulse");
    cmpVal(32'(updSeen), 32'(n + 1), "update count");
    axRead(ADDR_STATUS, ok(32'hA));
    axWrite(ADDR_IRQEN, 32'h0);
    axWrite(ADDR_STATUS, 32'h0);
    axWrite(ADDR_CTRL, 32'h8);
    axWrite(ADDR_IRQEN, 32'h2);
    axWrite(ADDR_SECONDS, 32'h3B);
    waitOe(1'b1, cnt);
    waitOe(1'b0, cnt);
    cmpVal(32'(cnt), 32'h7, "min pulse");
    axWrite(ADDR_IRQEN, 32'h0);
    axWrite(ADDR_STATUS, 32'h0);
    @(posedge ref_clk);
    alarmEvent <= 1'b1;
    @(posedge ref_clk);
    alarmEvent <= 1'b0;
    repeat (4) @(negedge ref_clk);
    cmpVal({30'h0, intPinOe, alarmSignalInternal}, 32'h0, "alarm masked");
    axRead(ADDR_STATUS, ok(32'hC));
    axWrite(ADDR_IRQEN, 32'h4);
    repeat (3) @(negedge ref_clk);
    cmpVal({30'h0, intPinOe, alarmSignalInternal}, 32'h3, "alarm on");
    axWrite(ADDR_STATUS, 32'h0);
    repeat (3) @(negedge ref_clk);
    cmpVal({30'h0, intPinOe, alarmSignalInternal}, 32'h0, "alarm clear");
    test_done();
  end
endmodule : countdown_and_update_interrupts_tb_top
